/* File: shc_config.sv */
// register bank and control logic for sync, lock-detect, holdover and reference selection
module shc_config (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [shc_pkg::SHC_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sync_in,
	input wire logic div_write,
	input wire logic qual_clk,
	input wire logic loop1_lock,
	input wire logic loop2_lock,
	input wire logic ref0_level,
	input wire logic ref1_level,
	input wire logic status0_in,
	input wire logic status1_in,
	output logic [5:0] group_sync,
	output logic sync_active,
	output logic sync_pin_out,
	output logic lock_pin_out,
	output logic status0_out,
	output logic status1_out,
	output logic holdover_active,
	output logic dac_track,
	output logic crystal_osc_enable,
	output logic [1:0] ref_select,
	output logic ref0_signal_loss_flag,
	output logic ref1_signal_loss_flag,
	output logic [2:0] sync_pin_type,
	output logic [2:0] lock_pin_type,
	output logic [2:0] status_pin0_type,
	output logic [2:0] status_pin1_type
);
	import shc_pkg::*;

	//////////////////////////////////////////////////////////////////////////////
	// registers
	// unmapped addresses and the read-only status word ignore writes
	logic [31:0] sync_and_osc_control_q;
	logic [31:0] lock_detect_control_q;
	logic [31:0] holdover_input_select_control_q;
	logic [31:0] input_loss_buffer_control_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_and_osc_control_q <= SHC_RST_SYNC; // [R01]
			lock_detect_control_q <= SHC_RST_LOCK; // [R01]
			holdover_input_select_control_q <= SHC_RST_HOLD; // [R01]
			input_loss_buffer_control_q <= SHC_RST_LOSS; // [R01]
		end else if (wr) begin
			case (addr)
				SHC_ADR_SYNC: sync_and_osc_control_q <= wdata;
				SHC_ADR_LOCK: lock_detect_control_q <= wdata;
				SHC_ADR_HOLD: holdover_input_select_control_q <= wdata;
				SHC_ADR_LOSS: input_loss_buffer_control_q <= wdata;
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// field views
	logic sync_enable;
	logic [5:0] group_sync_exclude;
	logic [1:0] sync_mux_sel;
	logic sync_qualify_by_output;
	logic sync_pin_polarity;
	logic sync_auto;
	logic [4:0] lock_pin_select;
	logic hold_sync_until_loop2_lock;
	logic hold_sync_until_loop1_lock;
	logic [1:0] holdover_mode;
	logic [2:0] status_pin1_select;
	logic [2:0] status_pin0_select;
	logic loop1_unlock_holdover_mask;
	logic [2:0] reference_select_mode;
	logic status_input_invert;
	logic ref1_usable;
	logic ref0_usable;
	logic [1:0] signal_loss_timeout;
	logic signal_loss_detect_enable;
	logic track_field;
	logic xtal_field;
	logic [2:0] sync_type_field;
	logic [2:0] lock_type_field;
	logic [2:0] stat0_type_field;
	logic [2:0] stat1_type_field;

	assign sync_enable = sync_and_osc_control_q[SHC_B_SYNC_EN];
	assign group_sync_exclude = sync_and_osc_control_q[SHC_B_EXCL_HI:SHC_B_EXCL_LO];
	assign sync_mux_sel = sync_and_osc_control_q[SHC_B_SMUX_HI:SHC_B_SMUX_LO];
	assign sync_qualify_by_output = sync_and_osc_control_q[SHC_B_QUAL];
	assign sync_pin_polarity = sync_and_osc_control_q[SHC_B_SPOL];
	assign sync_auto = sync_and_osc_control_q[SHC_B_AUTO];
	assign lock_pin_select = lock_detect_control_q[SHC_B_LMUX_HI:SHC_B_LMUX_LO];
	assign hold_sync_until_loop2_lock = lock_detect_control_q[SHC_B_HOLD2];
	assign hold_sync_until_loop1_lock = lock_detect_control_q[SHC_B_HOLD1];
	assign holdover_mode = lock_detect_control_q[SHC_B_HMODE_HI:SHC_B_HMODE_LO];
	assign status_pin1_select = holdover_input_select_control_q[SHC_B_S1MUX_HI:SHC_B_S1MUX_LO];
	assign status_pin0_select = holdover_input_select_control_q[SHC_B_S0MUX_HI:SHC_B_S0MUX_LO];
	assign loop1_unlock_holdover_mask = holdover_input_select_control_q[SHC_B_DLDMASK];
	assign reference_select_mode = holdover_input_select_control_q[SHC_B_RSEL_HI:SHC_B_RSEL_LO];
	assign status_input_invert = holdover_input_select_control_q[SHC_B_SINV];
	assign ref1_usable = holdover_input_select_control_q[SHC_B_REF1];
	assign ref0_usable = holdover_input_select_control_q[SHC_B_REF0];
	assign signal_loss_timeout = input_loss_buffer_control_q[SHC_B_LTO_HI:SHC_B_LTO_LO];
	assign signal_loss_detect_enable = input_loss_buffer_control_q[SHC_B_LOSEN];
	// pin type and enable fields only feed registered outputs
	assign track_field = lock_detect_control_q[SHC_B_TRACK];
	assign xtal_field = sync_and_osc_control_q[SHC_B_XTAL];
	assign sync_type_field = sync_and_osc_control_q[SHC_B_STYPE_HI:SHC_B_STYPE_LO];
	assign lock_type_field = lock_detect_control_q[SHC_B_PTYPE_HI:SHC_B_PTYPE_LO];
	assign stat0_type_field = holdover_input_select_control_q[SHC_B_S0TYPE_HI:SHC_B_S0TYPE_LO];
	assign stat1_type_field = input_loss_buffer_control_q[SHC_B_PTYPE_HI:SHC_B_PTYPE_LO];

	//////////////////////////////////////////////////////////////////////////////
	// static configuration outputs, registered
	always_ff @(posedge mclk) begin
		if (rst) begin
			dac_track <= 1'b0;
			crystal_osc_enable <= 1'b0;
			sync_pin_type <= 3'h0;
			lock_pin_type <= 3'h0;
			status_pin0_type <= 3'h0;
			status_pin1_type <= 3'h0;
		end else begin
			dac_track <= track_field; // [R12]
			crystal_osc_enable <= xtal_field; // [R08]
			sync_pin_type <= sync_type_field; // [R07]
			lock_pin_type <= lock_type_field; // [R07]
			status_pin0_type <= stat0_type_field; // [R21]
			status_pin1_type <= stat1_type_field; // [R21]
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// loss of signal
	logic los0;
	logic los1;
	logic [1:0] ref_level_v;
	logic [1:0] los_v;
	assign ref_level_v = {ref1_level, ref0_level};
	// both detectors share the enable and timeout fields of one register
	for (genvar r = 0; r < 2; r++) begin : g_los
		shc_los_det u_los (
			.mclk(mclk),
			.rst(rst),
			.enable(signal_loss_detect_enable),
			.timeout_sel(signal_loss_timeout),
			.ref_level(ref_level_v[r]),
			.loss_q(los_v[r])
		);
	end
	assign los0 = los_v[0];
	assign los1 = los_v[1];
	assign ref0_signal_loss_flag = los_v[0];
	assign ref1_signal_loss_flag = los_v[1];

	//////////////////////////////////////////////////////////////////////////////
	// sync: manual pin, auto on divider writes, lock-held
	logic sync_req;
	logic sync_pin_asserted;
	logic qual_prev_q;
	logic qual_ok;
	logic sync_fire;
	assign sync_pin_asserted = sync_pin_polarity ? !sync_in : sync_in; // [R05]
	// qualification counts a rising edge of the output, never a held level
	assign qual_ok = !sync_qualify_by_output || (qual_clk && !qual_prev_q); // [R04]
	assign sync_req = sync_pin_asserted || (sync_auto && div_write) // [R06]
		|| (hold_sync_until_loop2_lock && !loop2_lock) // [R10]
		|| (hold_sync_until_loop1_lock && !loop1_lock); // [R11]

	always_ff @(posedge mclk) begin
		if (rst) begin
			qual_prev_q <= 1'b0;
		end else begin
			qual_prev_q <= qual_clk;
		end
	end

	// a sync needs the global enable as well as a request
	assign sync_fire = sync_enable && sync_req && qual_ok;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_active <= 1'b0;
		end else begin
			sync_active <= sync_fire;
		end
	end

	// one flop per output group; an excluded group simply never sees the pulse
	for (genvar g = 0; g < 6; g++) begin : g_group
		always_ff @(posedge mclk) begin
			if (rst) begin
				group_sync[g] <= 1'b0;
			end else begin
				group_sync[g] <= sync_fire && !group_sync_exclude[g]; // [R02]
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// holdover
	logic loop1_prev_q;
	logic loop1_fall;
	// holdover ends as soon as loop 1 reports lock again, with no settling count
	shc_state_t state_q;
	assign loop1_fall = loop1_prev_q && !loop1_lock && !loop1_unlock_holdover_mask; // [R14]

	always_ff @(posedge mclk) begin
		if (rst) begin
			loop1_prev_q <= 1'b0;
		end else begin
			loop1_prev_q <= loop1_lock;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= SHC_IDLE;
		end else begin
			case (state_q)
				SHC_IDLE: begin
					if (holdover_mode == SHC_HMODE_ON && loop1_fall) begin
						state_q <= SHC_HOLD; // [R13]
					end
				end
				SHC_HOLD: begin
					if (holdover_mode != SHC_HMODE_ON || loop1_lock) begin
						state_q <= SHC_IDLE;
					end
				end
				default: state_q <= SHC_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			holdover_active <= 1'b0;
		end else begin
			holdover_active <= (state_q == SHC_HOLD);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// reference selection
	logic st0;
	logic st1;
	assign st0 = (reference_select_mode == SHC_RSEL_PIN) ? status0_in ^ status_input_invert
		: status0_in; // [R16]
	assign st1 = (reference_select_mode == SHC_RSEL_PIN) ? status1_in ^ status_input_invert
		: status1_in; // [R16]

	// modes other than pin select and manual fall back to first usable live input
	always_ff @(posedge mclk) begin
		if (rst) begin
			ref_select <= 2'h0;
		end else begin
			case (reference_select_mode)
				3'h0: ref_select <= 2'h0;
				3'h1: ref_select <= 2'h1;
				SHC_RSEL_PIN: ref_select <= {st1, st0};
				default: begin
					if (ref0_usable && !los0) begin
						ref_select <= 2'h0; // [R17]
					end else if (ref1_usable && !los1) begin
						ref_select <= 2'h1; // [R17]
					end else begin
						ref_select <= ref_select; // [R15]
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// pin multiplexers; code 0 always drives low
	logic [31:0] lock_src;
	logic [7:0] stat_src;
	logic [3:0] sync_src;
	assign lock_src = {27'h0, holdover_active, loop1_lock && loop2_lock, loop2_lock, loop1_lock, 1'b0}; // [R09]
	assign stat_src = {3'h0, los1, los0, holdover_active, loop1_lock, 1'b0}; // [R20]
	assign sync_src = {loop2_lock, loop1_lock, sync_active, 1'b0}; // [R03]

	shc_pin_mux #(.SEL_W(5)) u_lock (
		.mclk(mclk),
		.rst(rst),
		.sel(lock_pin_select),
		.sources(lock_src),
		.pin_q(lock_pin_out)
	);
	shc_pin_mux #(.SEL_W(3)) u_st0 (
		.mclk(mclk),
		.rst(rst),
		.sel(status_pin0_select),
		.sources(stat_src),
		.pin_q(status0_out)
	);
	shc_pin_mux #(.SEL_W(3)) u_st1 (
		.mclk(mclk),
		.rst(rst),
		.sel(status_pin1_select),
		.sources(stat_src),
		.pin_q(status1_out)
	);
	shc_pin_mux #(.SEL_W(2)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.sel(sync_mux_sel),
		.sources(sync_src),
		.pin_q(sync_pin_out)
	);

	//////////////////////////////////////////////////////////////////////////////
	// read port: data in the cycle after rd; unmapped reads zero
	// status word is assembled live and is read-only
	logic [31:0] status_word;
	assign status_word = {26'h0, ref_select, holdover_active, sync_active, los1, los0};
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (rd) begin
			case (addr)
				SHC_ADR_SYNC: rdata <= sync_and_osc_control_q;
				SHC_ADR_LOCK: rdata <= lock_detect_control_q;
				SHC_ADR_HOLD: rdata <= holdover_input_select_control_q;
				SHC_ADR_LOSS: rdata <= input_loss_buffer_control_q;
				SHC_ADR_STAT: rdata <= status_word;
				default: rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end
endmodule : shc_config

/* File: shc_pkg.sv */
// package: register offsets, field positions, reset values and timing for the sync/holdover config bank
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R01] all fields take defaults at reset
// [R02] exclusion bits 25:20 keep groups from sync
// [R03] sync_mux 19:18 drives sync pin output
// [R04] bit 17 qualifies sync by an output
// [R05] bit 16 sets sync input polarity
// [R06] bit 15 auto-syncs on divider writes
// [R07] pin type fields set direction and drive
// [R08] bit 5 enables crystal oscillator
// [R09] lock_pin_select 31:27 picks lock pin source
// [R10] bit 23 holds sync until loop2 lock
// [R11] bit 22 holds sync until loop1 lock
// [R12] bit 8 enables dac tracking
// [R13] holdover_mode 7:6 controls holdover entry
// [R14] bit 15 masks loop1 unlock holdover trigger
// [R15] reference_select_mode 11:9 chooses reference
// [R16] bit 8 inverts status inputs in mode 6
// [R17] bits 6,5 mark references usable
// [R18] timeout 31:30 sets loss delay
// [R19] bit 28 enables loss detection
// [R20] status pin mux fields select outputs
// [R21] status pin types default input pull-down
// [R22] loss clears when edges return
//////////////////////////////////////////////////////////////////////////////
package shc_pkg;
	localparam logic [3:0] SHC_OFS_SYNC = 4'h0;
	localparam logic [3:0] SHC_OFS_LOCK = 4'h4;
	localparam logic [3:0] SHC_OFS_HOLD = 4'h8;
	localparam logic [3:0] SHC_OFS_LOSS = 4'hc;
	localparam logic [4:0] SHC_OFS_STAT = 5'h10;
	localparam int SHC_ADDR_W = 5;
	localparam logic [4:0] SHC_ADR_SYNC = 5'h00;
	localparam logic [4:0] SHC_ADR_LOCK = 5'h04;
	localparam logic [4:0] SHC_ADR_HOLD = 5'h08;
	localparam logic [4:0] SHC_ADR_LOSS = 5'h0c;
	localparam logic [4:0] SHC_ADR_STAT = 5'h10;
	// reset images assembled from the field defaults
	localparam logic [31:0] SHC_RST_SYNC = 32'h0581_1000;
	localparam logic [31:0] SHC_RST_LOCK = 32'h1b00_0180;
	localparam logic [31:0] SHC_RST_HOLD = 32'h3b02_0660;
	localparam logic [31:0] SHC_RST_LOSS = 32'h1200_0000;
	localparam int SHC_B_SYNC_EN = 26;
	localparam int SHC_B_EXCL_HI = 25;
	localparam int SHC_B_EXCL_LO = 20;
	localparam int SHC_B_SMUX_HI = 19;
	localparam int SHC_B_SMUX_LO = 18;
	localparam int SHC_B_QUAL = 17;
	localparam int SHC_B_SPOL = 16;
	localparam int SHC_B_AUTO = 15;
	localparam int SHC_B_STYPE_HI = 14;
	localparam int SHC_B_STYPE_LO = 12;
	localparam int SHC_B_XTAL = 5;
	localparam int SHC_B_LMUX_HI = 31;
	localparam int SHC_B_LMUX_LO = 27;
	localparam int SHC_B_PTYPE_HI = 26;
	localparam int SHC_B_PTYPE_LO = 24;
	localparam int SHC_B_HOLD2 = 23;
	localparam int SHC_B_HOLD1 = 22;
	localparam int SHC_B_TRACK = 8;
	localparam int SHC_B_HMODE_HI = 7;
	localparam int SHC_B_HMODE_LO = 6;
	localparam int SHC_B_S1MUX_HI = 22;
	localparam int SHC_B_S1MUX_LO = 20;
	localparam int SHC_B_S0TYPE_HI = 18;
	localparam int SHC_B_S0TYPE_LO = 16;
	localparam int SHC_B_DLDMASK = 15;
	localparam int SHC_B_S0MUX_HI = 14;
	localparam int SHC_B_S0MUX_LO = 12;
	localparam int SHC_B_RSEL_HI = 11;
	localparam int SHC_B_RSEL_LO = 9;
	localparam int SHC_B_SINV = 8;
	localparam int SHC_B_REF1 = 6;
	localparam int SHC_B_REF0 = 5;
	localparam int SHC_B_LTO_HI = 31;
	localparam int SHC_B_LTO_LO = 30;
	localparam int SHC_B_LOSEN = 28;
	localparam logic [2:0] SHC_RSEL_PIN = 3'h6;
	localparam logic [1:0] SHC_HMODE_ON = 2'h2;
	// loss timeout: code 0 is 1200 ns; longer codes double, a plain choice
	localparam int SHC_CLK_NS = 20;
	localparam int SHC_LOS_BASE_NS = 1200;
	localparam int SHC_LOS_BASE_CYC = SHC_LOS_BASE_NS / SHC_CLK_NS;
	localparam int SHC_LOS_CNT_W = 12;
	typedef enum logic [2:0] {
		SHC_IDLE = 3'b001,
		SHC_SYNC = 3'b010,
		SHC_HOLD = 3'b100
	} shc_state_t;
endpackage : shc_pkg

/* File: shc_los_det.sv */
// loss-of-signal detector for one reference input
module shc_los_det (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [1:0] timeout_sel,
	input wire logic ref_level,
	output logic loss_q
);
	import shc_pkg::*;
	logic [SHC_LOS_CNT_W-1:0] cnt_q;
	logic [SHC_LOS_CNT_W-1:0] limit;
	logic prev_q;
	logic edge_seen;
	assign limit = SHC_LOS_CNT_W'(SHC_LOS_BASE_CYC) << timeout_sel; // [R18]
	assign edge_seen = ref_level != prev_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= ref_level;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
			loss_q <= 1'b0;
		end else if (!enable) begin
			cnt_q <= '0;
			loss_q <= 1'b0; // [R19]
		end else if (edge_seen) begin
			cnt_q <= '0;
			loss_q <= 1'b0; // [R22]
		end else if (cnt_q >= limit) begin
			loss_q <= 1'b1; // [R18]
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : shc_los_det

/* File: shc_pin_mux.sv */
// selects one source from a bus of internal signals for a pin
module shc_pin_mux #(
	parameter int SEL_W = 3
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [SEL_W-1:0] sel,
	input wire logic [(1<<SEL_W)-1:0] sources,
	output logic pin_q
);
	// code 0 of each source bus is tied low by the caller
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= sources[sel];
		end
	end
endmodule : shc_pin_mux

/* File: shc_config_properties.sv */
// checker: concurrent properties for the sync, lock and holdover configuration bank
//////////////////////////////////////////////////////////////////////////////
module shc_config_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [shc_pkg::SHC_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic loop1_lock,
	input wire logic loop2_lock,
	input wire logic ref0_level,
	input wire logic [5:0] group_sync,
	input wire logic sync_active,
	input wire logic sync_pin_out,
	input wire logic lock_pin_out,
	input wire logic holdover_active,
	input wire logic dac_track,
	input wire logic crystal_osc_enable,
	input wire logic ref0_signal_loss_flag,
	input wire logic ref1_signal_loss_flag,
	input wire logic [2:0] sync_pin_type,
	input wire logic [2:0] lock_pin_type,
	input wire logic [2:0] status_pin0_type,
	input wire logic [2:0] status_pin1_type
);
	timeunit 1ns;
	timeprecision 1ps;
	import shc_pkg::*;
	// shadow copies of the four control registers, rebuilt from host writes
	logic [31:0] sync_q, lock_q, hold_q, loss_q, view;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_q <= SHC_RST_SYNC;
			lock_q <= SHC_RST_LOCK;
			hold_q <= SHC_RST_HOLD;
			loss_q <= SHC_RST_LOSS;
		end else if (wr) begin
			if (addr == SHC_ADR_SYNC) sync_q <= wdata;
			if (addr == SHC_ADR_LOCK) lock_q <= wdata;
			if (addr == SHC_ADR_HOLD) hold_q <= wdata;
			if (addr == SHC_ADR_LOSS) loss_q <= wdata;
		end
	end
	always_comb begin
		case (addr)
			SHC_ADR_SYNC: view = sync_q;
			SHC_ADR_LOCK: view = lock_q;
			SHC_ADR_HOLD: view = hold_q;
			SHC_ADR_LOSS: view = loss_q;
			default: view = 32'h0;
		endcase
	end
	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence ref0_edge;
		loss_q[28] && ref0_level != $past(ref0_level);
	endsequence
	sequence loop1_drop;
		$fell(loop1_lock) && lock_q[7:6] == SHC_HMODE_ON && !hold_q[15];
	endsequence
	a_read_back: assert property (rd && addr != SHC_ADR_STAT |=> rdata == $past(view))
		else $error("read data differs from register contents");
	a_cfg_outputs: assert property (!wr [*3] |-> crystal_osc_enable == sync_q[5]
		&& dac_track == lock_q[8] && sync_pin_type == sync_q[14:12]
		&& lock_pin_type == lock_q[26:24] && status_pin0_type == hold_q[18:16]
		&& status_pin1_type == loss_q[26:24]) else $error("config output differs from register");
	a_lock_pin_both: assert property ((lock_q[31:27] == 5'h03 && $stable(loop1_lock)
		&& $stable(loop2_lock)) [*3] |-> lock_pin_out == (loop1_lock && loop2_lock))
		else $error("lock pin not the joint lock");
	a_sync_pin_low: assert property ((sync_q[19:18] == 2'h0) [*3] |-> !sync_pin_out)
		else $error("sync pin not low for code 0");
	a_excluded_groups: assert property ($stable(sync_q[25:20]) [*3]
		|-> (group_sync & sync_q[25:20]) == 6'h00) else $error("excluded group synced");
	a_loss_off: assert property ((!loss_q[28]) [*3]
		|-> !ref0_signal_loss_flag && !ref1_signal_loss_flag) else $error("loss flag while off");
	a_loss_clears: assert property (ref0_edge |-> ##[1:3] !ref0_signal_loss_flag)
		else $error("loss flag kept despite edges");
	a_holdover_entry: assert property (loop1_drop |-> ##[1:3] holdover_active)
		else $error("holdover not entered on unlock");
	a_holdover_masked: assert property ($fell(loop1_lock) && hold_q[15] && !holdover_active
		|=> !holdover_active [*3]) else $error("masked unlock entered holdover");
	a_sync_lock_hold: assert property ((sync_q[26] && !sync_q[17]
		&& ((lock_q[23] && !loop2_lock) || (lock_q[22] && !loop1_lock))) [*3] |-> sync_active)
		else $error("sync not held while loop unlocked");
endmodule : shc_config_properties

bind shc_config shc_config_properties i_shc_config_properties (
	.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.loop1_lock(loop1_lock), .loop2_lock(loop2_lock), .ref0_level(ref0_level),
	.group_sync(group_sync), .sync_active(sync_active), .sync_pin_out(sync_pin_out),
	.lock_pin_out(lock_pin_out), .holdover_active(holdover_active), .dac_track(dac_track),
	.crystal_osc_enable(crystal_osc_enable), .ref0_signal_loss_flag(ref0_signal_loss_flag),
	.ref1_signal_loss_flag(ref1_signal_loss_flag), .sync_pin_type(sync_pin_type),
	.lock_pin_type(lock_pin_type), .status_pin0_type(status_pin0_type),
	.status_pin1_type(status_pin1_type)
);

/* File: shc_config_bench.sv */
// testbench: register access and control scenarios for the configuration bank
module shc_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import shc_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, div_write = 1'b0, qual_clk = 1'b0;
	logic sync_in = 1'b1, loop1_lock = 1'b1, loop2_lock = 1'b1, ref_run = 1'b0, seen;
	logic ref0_level = 1'b0, ref1_level = 1'b0, status0_in = 1'b0, status1_in = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [31:0] dflt [4];
	logic [5:0] group_sync;
	logic sync_active, sync_pin_out, lock_pin_out, status0_out, status1_out, holdover_active;
	logic dac_track, crystal_osc_enable, ref0_signal_loss_flag, ref1_signal_loss_flag;
	logic [1:0] ref_select;
	logic [2:0] sync_pin_type, lock_pin_type, status_pin0_type, status_pin1_type;
	int mismatches = 0, check_count = 0, cycles = 0;
	shc_config i_shc_config (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sync_in(sync_in), .div_write(div_write), .qual_clk(qual_clk), .loop1_lock(loop1_lock),
		.loop2_lock(loop2_lock), .ref0_level(ref0_level), .ref1_level(ref1_level),
		.status0_in(status0_in), .status1_in(status1_in), .group_sync(group_sync),
		.sync_active(sync_active), .sync_pin_out(sync_pin_out), .lock_pin_out(lock_pin_out),
		.status0_out(status0_out), .status1_out(status1_out), .holdover_active(holdover_active),
		.dac_track(dac_track), .crystal_osc_enable(crystal_osc_enable), .ref_select(ref_select),
		.ref0_signal_loss_flag(ref0_signal_loss_flag),
		.ref1_signal_loss_flag(ref1_signal_loss_flag), .sync_pin_type(sync_pin_type),
		.lock_pin_type(lock_pin_type), .status_pin0_type(status_pin0_type),
		.status_pin1_type(status_pin1_type)
	);
	//////////////////////////////////////////////////////////////////////////////
	always #10 mclk = ~mclk;
	// reference inputs only toggle while a scenario wants live clocks
	always @(posedge mclk) begin
		if (ref_run) begin
			ref0_level <= ~ref0_level;
			ref1_level <= ~ref1_level;
		end
	end
	// whole run is well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic conclude();
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic wr32(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr32
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rdc
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		// reset images built field by field
		dflt = '{(32'h1 << 26) | (32'h18 << 20) | (32'h1 << 16) | (32'h1 << 12),
			(32'h3 << 27) | (32'h3 << 24) | (32'h1 << 8) | (32'h2 << 6),
			(32'h7 << 27) | (32'h3 << 24) | (32'h2 << 16) | (32'h3 << 9) | (32'h3 << 5),
			(32'h1 << 28) | (32'h2 << 24)};
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		settle(3);
		check(dac_track, 1'b1);
		check(crystal_osc_enable, 1'b0);
		check({sync_pin_type, lock_pin_type}, 6'h0b);
		check({status_pin0_type, status_pin1_type}, 6'h12);
		check(status0_out, 1'b0);
		check(group_sync, 6'h00);
		for (int i = 0; i < 4; i++) begin
			rdc(5'(i * 4), dflt[i]);
			wr32(5'(i * 4), 32'h5a5a_a5a5 ^ dflt[i]);
			rdc(5'(i * 4), 32'h5a5a_a5a5 ^ dflt[i]);
			wr32(5'(i * 4), dflt[i]);
		end
		wr32(5'h14, 32'hffff_ffff);
		rdc(5'h14, 32'h0);
		loop2_lock <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr32(SHC_ADR_SYNC, dflt[0] | 32'h20 | (32'(c) << 18));
			settle(4);
			check(sync_pin_out, c == 2);
		end
		check(crystal_osc_enable, 1'b1);
		loop2_lock <= 1'b1;
		wr32(SHC_ADR_SYNC, dflt[0]);
		sync_in <= 1'b0;
		settle(4);
		check(group_sync, 6'h27);
		sync_in <= 1'b1;
		wr32(SHC_ADR_SYNC, dflt[0] & 32'hfc0e_ffff | 32'h02a0_0000);
		settle(4);
		check(group_sync, 6'h15);
		sync_in <= 1'b0;
		settle(4);
		check(group_sync, 6'h00);
		sync_in <= 1'b1;
		wr32(SHC_ADR_SYNC, dflt[0] | 32'h2_0000);
		sync_in <= 1'b0;
		settle(4);
		check(sync_active, 1'b0);
		qual_clk <= 1'b1;
		settle(1);
		check(sync_active, 1'b1);
		settle(2);
		check(sync_active, 1'b0);
		sync_in <= 1'b1;
		qual_clk <= 1'b0;
		for (int a = 0; a < 2; a++) begin
			wr32(SHC_ADR_SYNC, dflt[0] | (32'(a) << 15));
			@(posedge mclk);
			div_write <= 1'b1;
			@(posedge mclk);
			div_write <= 1'b0;
			seen = 1'b0;
			repeat (4) begin
				#1 seen = seen | sync_active;
				@(posedge mclk);
			end
			check(seen, a == 1);
		end
		wr32(SHC_ADR_SYNC, dflt[0]);
		for (int i = 3; i >= 0; i--) begin
			{loop1_lock, loop2_lock} <= 2'(i);
			settle(4);
			check(lock_pin_out, i == 3);
			check(holdover_active, !i[1]);
		end
		{loop1_lock, loop2_lock} <= 2'h3;
		settle(4);
		check(holdover_active, 1'b0);
		wr32(SHC_ADR_HOLD, dflt[2] | 32'h8000);
		loop1_lock <= 1'b0;
		settle(4);
		check(holdover_active, 1'b0);
		loop1_lock <= 1'b1;
		// the unlock mask stays set so dropping loop 1 here does not enter holdover
		for (int b = 0; b < 2; b++) begin
			wr32(SHC_ADR_LOCK, dflt[1] | (32'h1 << (22 + b)));
			{loop2_lock, loop1_lock} <= (b == 1) ? 2'h1 : 2'h2;
			settle(4);
			check(sync_active, 1'b1);
			{loop2_lock, loop1_lock} <= 2'h3;
			settle(4);
			check(sync_active, 1'b0);
		end
		wr32(SHC_ADR_HOLD, dflt[2] | 32'h0010_1000);
		settle(4);
		check(status0_out, 1'b1);
		check(status1_out, 1'b1);
		ref_run <= 1'b1;
		settle(10);
		check(ref0_signal_loss_flag, 1'b0);
		ref_run <= 1'b0;
		settle(50);
		check(ref0_signal_loss_flag, 1'b0);
		settle(20);
		check({ref1_signal_loss_flag, ref0_signal_loss_flag}, 2'h3);
		ref_run <= 1'b1;
		settle(4);
		check(ref0_signal_loss_flag, 1'b0);
		ref_run <= 1'b0;
		wr32(SHC_ADR_LOSS, 32'h0);
		settle(80);
		check(ref0_signal_loss_flag, 1'b0);
		wr32(SHC_ADR_LOSS, dflt[3]);
		ref_run <= 1'b1;
		wr32(SHC_ADR_HOLD, dflt[2] & ~32'h20);
		settle(4);
		check(ref_select, 2'h1);
		for (int m = 0; m < 2; m++) begin
			wr32(SHC_ADR_HOLD, dflt[2] & ~32'he00 | (32'(m) << 9));
			settle(4);
			check(ref_select, 2'(m));
		end
		status0_in <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			wr32(SHC_ADR_HOLD, dflt[2] & ~32'he00 | 32'hc00 | (32'(v) << 8));
			settle(4);
			check(ref_select, (v == 1) ? 2'h2 : 2'h1);
		end
		conclude();
	end
endmodule : shc_config_bench
